// file: rtl/codec_control_port_pins.sv
// Purpose: Serial control port slave plus latch output, key sense and aux clock pins.
// Assumes: clk_sys is well above twice the control clock rate; all pins are asynchronous.
// Notes: Control clock edges are found by oversampling; no logic runs on ctrl_clk itself.
`timescale 1ns/10ps
`default_nettype none
module codec_control_port_pins
  import ctrl_port_pkg::*;
#(
  parameter int REG_COUNT = NUM_REGS
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic ce,
  input wire logic ctrl_clk,
  input wire logic chip_select_n,
  input wire logic ctrl_serial_in,
  output logic ctrl_serial_out,
  output logic ctrl_serial_out_en,
  output logic latch_out_pin,
  input wire logic remote_key_in,
  output logic remote_key_pressed,
  input wire logic aux_timing_clk,
  output logic [AUX_SEL_W-1:0] aux_freq_sel,
  output logic aux_tick,
  input wire logic por_event
);
  logic [4:0] pins_sync;
  logic clk_prev;
  logic aux_prev;
  port_state_t state;
  port_state_t next_state;
  logic [CNT_W-1:0] bit_cnt;
  logic [INSTR_BITS-1:0] instr;
  logic [DATA_BITS-1:0] shift_in;
  logic [DATA_BITS-1:0] regs [REG_COUNT];

  // Resynchronise every pin before use; the slow link clock is sampled, not used as a clock.
  // Reset values match the idle pins (key released, deselected, clocks and data low), so no false edge follows reset.
  pin_sync #(.WIDTH(5), .INIT(5'h18)) u_sync (
    .clk_sys(clk_sys),
    .reset(reset),
    .ce(ce),
    .pin_in({remote_key_in, chip_select_n, aux_timing_clk, ctrl_clk, ctrl_serial_in}),
    .pin_sync_out(pins_sync)
  );

  wire sin_sync = pins_sync[0];
  wire clk_sync = pins_sync[1];
  wire aux_sync = pins_sync[2];
  wire cs_n_sync = pins_sync[3];
  wire key_sync = pins_sync[4];
  wire selected = !cs_n_sync;
  wire rise_evt = ce && selected && clk_sync && !clk_prev;
  wire fall_evt = ce && selected && !clk_sync && clk_prev;
  wire is_read = instr[READ_FLAG_BIT];
  wire [ADDR_W-1:0] addr = instr[ADDR_W-1:0];
  wire [DATA_BITS-1:0] next_shift = {shift_in[DATA_BITS-2:0], sin_sync};
  wire instr_done = rise_evt && (state == ST_INSTR) && (bit_cnt == LAST_INSTR_CNT);
  wire wr_commit = rise_evt && (state == ST_DATA) && (bit_cnt == LAST_DATA_CNT) && !is_read;
  wire [DATA_BITS-1:0] status_word = {{(DATA_BITS-1){1'b0}}, remote_key_pressed};
  wire [DATA_BITS-1:0] rd_word = (addr == STATUS_IDX) ? status_word : regs[addr];
  wire [2:0] out_idx = ~bit_cnt[2:0];

  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (selected) begin
          next_state = ST_INSTR;
        end
      end
      ST_INSTR: begin
        if (instr_done) begin
          next_state = ST_DATA;
        end
      end
      ST_DATA: begin
        if (rise_evt && bit_cnt == LAST_DATA_CNT) begin
          next_state = ST_DONE;
        end
      end
      ST_DONE: begin
        next_state = ST_DONE;
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
    // Deselecting aborts any partial transfer without a register write.
    if (!selected) begin
      next_state = ST_IDLE;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      state <= ST_IDLE;
      clk_prev <= 1'b0;
      aux_prev <= 1'b0;
    end else if (ce) begin
      state <= next_state;
      clk_prev <= clk_sync;
      aux_prev <= aux_sync;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      bit_cnt <= '0;
      instr <= '0;
      shift_in <= '0;
    end else if (!selected && ce) begin
      bit_cnt <= '0;
    end else if (rise_evt && state != ST_DONE) begin
      bit_cnt <= bit_cnt + 4'h1;
      shift_in <= next_shift;
      if (state == ST_INSTR) begin
        instr <= next_shift;
      end
    end
  end

  // Output data changes only on falling edges, so the host samples it stable on the rise.
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      ctrl_serial_out <= 1'b0;
    end else if (fall_evt && state == ST_DATA && is_read) begin
      ctrl_serial_out <= rd_word[out_idx];
    end
  end

  assign ctrl_serial_out_en = selected && (state == ST_DATA) && is_read;

  genvar g;
  generate
    for (g = 0; g < REG_COUNT; g++) begin : g_reg
      always_ff @(posedge clk_sys) begin
        if (reset || (ce && por_event)) begin
          regs[g] <= REG_RESET;
        end else if (wr_commit && addr == ADDR_W'(g) && addr != STATUS_IDX) begin
          regs[g] <= next_shift;
        end
      end
    end
  endgenerate

  assign latch_out_pin = !regs[CTRL_ONE_IDX][LATCH_BIT];
  assign aux_freq_sel = regs[CTRL_ZERO_IDX][AUX_SEL_LSB +: AUX_SEL_W];

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      remote_key_pressed <= 1'b0;
      aux_tick <= 1'b0;
    end else if (ce) begin
      remote_key_pressed <= !key_sync;
      aux_tick <= aux_sync && !aux_prev;
    end
  end

  chk_capture_bit: assert property (@(posedge clk_sys) disable iff (reset)
    (rise_evt && state == ST_INSTR) |=> (instr[0] == $past(sin_sync)))
    else $error("serial input bit not captured on rising edge");
  chk_cs_ignore: assert property (@(posedge clk_sys) disable iff (reset)
    (ce && cs_n_sync) |=> (state == ST_IDLE && bit_cnt == 4'h0))
    else $error("transfer state kept while deselected");
  chk_write_no_drive: assert property (@(posedge clk_sys) disable iff (reset)
    (state == ST_DATA && !is_read) |-> !ctrl_serial_out_en)
    else $error("output driven during a write instruction");
  chk_latch_pin: assert property (@(posedge clk_sys) disable iff (reset)
    (wr_commit && addr == CTRL_ONE_IDX && !por_event) |=> (latch_out_pin == !$past(sin_sync)))
    else $error("latch pin not inverse of written bit");
  chk_key_sense: assert property (@(posedge clk_sys) disable iff (reset)
    (ce && !key_sync) |=> remote_key_pressed)
    else $error("low key input not seen as pressed");
  chk_aux_select: assert property (@(posedge clk_sys) disable iff (reset)
    (wr_commit && addr == CTRL_ZERO_IDX && !por_event) |=> (aux_freq_sel == $past(next_shift[AUX_SEL_LSB +: AUX_SEL_W])))
    else $error("aux frequency field not updated");
  chk_out_falling: assert property (@(posedge clk_sys) disable iff (reset)
    $changed(ctrl_serial_out) |-> $past(fall_evt))
    else $error("serial output changed away from a falling edge");
  chk_por_high: assert property (@(posedge clk_sys) disable iff (reset)
    (ce && por_event) |=> latch_out_pin)
    else $error("latch pin not high after power-on reset");
  chk_out_release: assert property (@(posedge clk_sys) disable iff (reset)
    cs_n_sync |-> !ctrl_serial_out_en)
    else $error("serial output driven while deselected");

  cov_read_xfer: cover property (@(posedge clk_sys) disable iff (reset)
    (state == ST_DATA && is_read) ##[1:400] (state == ST_DONE));
  cov_write_xfer: cover property (@(posedge clk_sys) disable iff (reset) wr_commit);
  cov_por_latch: cover property (@(posedge clk_sys) disable iff (reset)
    !latch_out_pin ##1 (ce && por_event) ##1 latch_out_pin);
endmodule
`default_nettype wire

// file: common/ctrl_port_pkg.sv
// Purpose: Shared constants for the serial control port and its digital pins.
// Assumes: One instruction byte followed by one data byte per transfer.
// Notes: Register indices and field positions are local to this block.
package ctrl_port_pkg;
  localparam int INSTR_BITS = 8;
  localparam int DATA_BITS = 8;
  localparam int CNT_W = 4;
  localparam logic [3:0] LAST_INSTR_CNT = 4'h7;
  localparam logic [3:0] LAST_DATA_CNT = 4'hF;
  // Instruction byte layout: read flag and register index.
  localparam int READ_FLAG_BIT = 7;
  localparam int ADDR_W = 3;
  localparam int NUM_REGS = 8;
  localparam logic [2:0] CTRL_ZERO_IDX = 3'h0;
  localparam logic [2:0] CTRL_ONE_IDX = 3'h1;
  localparam logic [2:0] STATUS_IDX = 3'h7;
  // Field positions.
  localparam int AUX_SEL_LSB = 4;
  localparam int AUX_SEL_W = 2;
  localparam int LATCH_BIT = 0;
  localparam int KEY_STATUS_BIT = 0;
  localparam logic [7:0] REG_RESET = 8'h00;
  // Auxiliary timing clock frequency codes.
  localparam logic [1:0] AUX_512K = 2'h0;
  localparam logic [1:0] AUX_1536K = 2'h1;
  localparam logic [1:0] AUX_2048K = 2'h2;
  localparam logic [1:0] AUX_2560K = 2'h3;
  localparam int AUX_512K_KHZ = 512;
  localparam int AUX_1536K_KHZ = 1536;
  localparam int AUX_2048K_KHZ = 2048;
  localparam int AUX_2560K_KHZ = 2560;
  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_INSTR = 4'h2,
    ST_DATA = 4'h4,
    ST_DONE = 4'h8
  } port_state_t;
endpackage

// file: rtl/pin_sync.sv
// Purpose: Two-flop synchroniser for a group of asynchronous pins.
// Assumes: Inputs are quasi-static relative to clk_sys or are clocks far below it.
// Notes: The first stage feeds only the second stage.
`timescale 1ns/10ps
`default_nettype none
module pin_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] INIT = '0
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic ce,
  input wire logic [WIDTH-1:0] pin_in,
  output logic [WIDTH-1:0] pin_sync_out
);
  logic [WIDTH-1:0] stage_one;

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      stage_one <= INIT;
      pin_sync_out <= INIT;
    end else if (ce) begin
      stage_one <= pin_in;
      pin_sync_out <= stage_one;
    end
  end
endmodule
`default_nettype wire

// file: testbench/host_ctrl_model.sv
// Purpose: Host model that drives the serial control channel.
// Assumes: All pins change at falling clk_sys edges; ctrl_clk period is eight clk_sys cycles.
// Notes: Between frames ctrl_clk stands low and the data line carries the inverse of its last bit.
`timescale 1ns/10ps
`default_nettype none
module host_ctrl_model (
  input wire logic clk_sys,
  input wire logic ctrl_serial_out,
  input wire logic ctrl_serial_out_en,
  output logic ctrl_clk,
  output logic chip_select_n,
  output logic ctrl_serial_in
);
  // A released output has no pull, so the host sees the opposite of the last driven bit.
  wire line_seen = ctrl_serial_out_en ? ctrl_serial_out : ~ctrl_serial_out;
  initial begin
    ctrl_clk = 1'b0;
    chip_select_n = 1'b1;
    ctrl_serial_in = 1'b0;
  end
  // With sel low the clock still runs, so a deselected device can be shown to ignore it.
  task automatic xfer(input logic sel, input int nbits, input logic [15:0] word, output logic [7:0] rd,
                      output logic en_seen);
    int i;
    rd = 8'h00;
    en_seen = 1'b0;
    @(negedge clk_sys);
    chip_select_n = ~sel;
    repeat (4) @(negedge clk_sys);
    for (i = 0; i < nbits; i++) begin
      ctrl_serial_in = word[15-i];
      repeat (4) @(negedge clk_sys);
      ctrl_clk = 1'b1;
      // The device moves its output only after the next fall, so mid-high capture is safe.
      repeat (2) @(negedge clk_sys);
      if (i >= 8) begin
        rd = {rd[6:0], line_seen};
        if (ctrl_serial_out_en === 1'b1) en_seen = 1'b1;
      end
      repeat (2) @(negedge clk_sys);
      ctrl_clk = 1'b0;
    end
    repeat (4) @(negedge clk_sys);
    chip_select_n = 1'b1;
    ctrl_serial_in = ~ctrl_serial_in;
    repeat (4) @(negedge clk_sys);
  endtask
endmodule
`default_nettype wire

// file: testbench/codec_control_port_pins_test.sv
// Purpose: Self-checking bench for the control port and its pins.
// Assumes: Registers other than index 7 are plain storage that reads back.
// Notes: Random stimulus from a fixed seed; ce is held high except in one freeze test.
`timescale 1ns/10ps
`default_nettype none
module codec_control_port_pins_test;
  import ctrl_port_pkg::*;
  logic clk_sys, reset, ctrl_clk, chip_select_n, ctrl_serial_in, ctrl_serial_out, ctrl_serial_out_en;
  logic latch_out_pin, remote_key_in, remote_key_pressed, aux_timing_clk, aux_tick, por_event;
  logic aux_run, en, key_exp, ce;
  logic [1:0] aux_freq_sel;
  logic [2:0] a;
  logic [7:0] rd, d;
  logic [7:0] model [8];
  int fail_count = 0, num_checks = 0, seed = 32'hA7122101, edges = 0, ticks = 0, i;
  codec_control_port_pins codec_control_port_pins_inst (.clk_sys, .reset, .ce, .ctrl_clk, .chip_select_n,
    .ctrl_serial_in, .ctrl_serial_out, .ctrl_serial_out_en, .latch_out_pin, .remote_key_in, .remote_key_pressed,
    .aux_timing_clk, .aux_freq_sel, .aux_tick, .por_event);
  host_ctrl_model host_ctrl_model_inst (.clk_sys, .ctrl_serial_out, .ctrl_serial_out_en, .ctrl_clk,
    .chip_select_n, .ctrl_serial_in);
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  initial begin
    aux_timing_clk = 1'b0;
    forever begin
      repeat (20) @(negedge clk_sys);
      if (aux_run) aux_timing_clk = ~aux_timing_clk;
    end
  end
  always @(posedge aux_timing_clk) edges++;
  always @(posedge clk_sys) if (aux_tick === 1'b1) ticks++;
  function automatic logic [7:0] expect_rd(input logic [2:0] idx);
    return (idx == STATUS_IDX) ? {7'h00, key_exp} : model[idx];
  endfunction
  task check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task wrap_up;
    $display("checks %0d failures %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task wr(input logic [2:0] idx, input logic [7:0] val);
    host_ctrl_model_inst.xfer(1'b1, 16, {5'h00, idx, val}, rd, en);
    check("write output enable", {7'h00, en}, 8'h00);
    if (idx != STATUS_IDX) model[idx] = val;
  endtask
  task rdchk(input logic [2:0] idx);
    host_ctrl_model_inst.xfer(1'b1, 16, {5'h10, idx, 8'($random(seed))}, rd, en);
    check("read data", rd, expect_rd(idx));
    check("read output enable", {7'h00, en}, 8'h01);
  endtask
  task pins;
    check("aux select", {6'h00, aux_freq_sel}, {6'h00, model[0][AUX_SEL_LSB+:AUX_SEL_W]});
    check("latch pin", {7'h00, latch_out_pin}, {7'h00, ~model[1][LATCH_BIT]});
  endtask
  initial begin
    #900000;
    fail_count++;
    wrap_up;
  end
  initial begin
    reset = 1'b1;
    ce = 1'b1;
    por_event = 1'b0;
    remote_key_in = 1'b1;
    aux_run = 1'b0;
    key_exp = 1'b0;
    for (i = 0; i < 8; i++) model[i] = REG_RESET;
    repeat (3) @(negedge clk_sys);
    reset = 1'b0;
    pins();
    $display("test reset done");
    aux_run = 1'b1;
    // The first four passes set every aux frequency code in turn.
    for (i = 0; i < 20; i++) begin
      a = (i < 4) ? CTRL_ZERO_IDX : 3'($random(seed));
      d = 8'($random(seed));
      if (i < 4) d[AUX_SEL_LSB+:AUX_SEL_W] = 2'(i);
      wr(a, d);
      rdchk(a);
      pins();
    end
    $display("test random registers done");
    // With ce low the synchroniser and key flop must hold, so the press stays unseen.
    ce = 1'b0;
    remote_key_in = 1'b0;
    repeat (6) @(negedge clk_sys);
    check("key frozen", {7'h00, remote_key_pressed}, 8'h00);
    ce = 1'b1;
    key_exp = 1'b1;
    repeat (5) @(negedge clk_sys);
    check("key pressed", {7'h00, remote_key_pressed}, 8'h01);
    wr(STATUS_IDX, 8'hFF);
    rdchk(STATUS_IDX);
    remote_key_in = 1'b1;
    key_exp = 1'b0;
    repeat (5) @(negedge clk_sys);
    check("key released", {7'h00, remote_key_pressed}, 8'h00);
    rdchk(STATUS_IDX);
    $display("test key done");
    wr(CTRL_ONE_IDX, 8'h01);
    host_ctrl_model_inst.xfer(1'b0, 16, {5'h00, CTRL_ONE_IDX, 8'h00}, rd, en);
    pins();
    host_ctrl_model_inst.xfer(1'b1, 12, {5'h00, CTRL_ONE_IDX, 8'h00}, rd, en);
    pins();
    rdchk(CTRL_ONE_IDX);
    $display("test deselect and abort done");
    wr(CTRL_ZERO_IDX, 8'h30);
    por_event = 1'b1;
    @(negedge clk_sys);
    por_event = 1'b0;
    for (i = 0; i < 8; i++) model[i] = REG_RESET;
    @(negedge clk_sys);
    pins();
    rdchk(CTRL_ONE_IDX);
    $display("test power on event done");
    aux_run = 1'b0;
    repeat (30) @(negedge clk_sys);
    check("aux ticks", 8'(ticks), 8'(edges));
    $display("test aux clock done");
    wrap_up;
  end
endmodule
`default_nettype wire
